// ### cbap_pkg.sv
// Constants and carrier types for the host bus access port.
// Assumes the port logic runs on the master clock named in the timing figures.
package cbap_pkg;

  // Completion latency window, in master clock cycles after the access starts
  localparam int MIN_ACK_CYC = 6;
  localparam int MAX_ACK_CYC = 60;
  localparam int CNT_W = 6;

  // Bus widths: word address A[15:1] and a 16-bit data bus
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;

  // Strobe style selection
  localparam logic MODE_SEPARATE = 1'h0;
  localparam logic MODE_DATA_STROBE = 1'h1;

  // Address space selection carried by the memory select bit
  localparam logic SPACE_REGISTERS = 1'h0;
  localparam logic SPACE_MEMORY = 1'h1;

  // Idle levels of the handshake outputs
  localparam logic READY_IDLE = 1'h0;
  localparam logic DACK_N_IDLE = 1'h1;

  // Request issued to the internal register file or memory controller
  typedef struct packed {
    logic write;
    logic mem;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cbap_req_t;

  // Answer from the internal side
  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] rdata;
  } cbap_rsp_t;

endpackage

// ### cbap_ack_timer.sv
// Latency counter for one host access and the decision when to complete it.
// Assumes start is a one-cycle pulse at the edge where the access is taken.
`timescale 1ns/10ps
module cbap_ack_timer #(
  parameter int MIN_CYC = cbap_pkg::MIN_ACK_CYC,
  parameter int MAX_CYC = cbap_pkg::MAX_ACK_CYC,
  parameter int CNT_W = cbap_pkg::CNT_W
) (
  input wire logic clock, // Master clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic start, // Access taken this cycle
  input wire logic armed, // Waiting for completion
  input wire logic is_read, // Read needs one extra cycle for data setup
  input wire logic done, // Internal answer present
  output logic [CNT_W-1:0] count, // Cycles since the access started
  output logic fire // Leave the wait state now
);

  // Thresholds: a read leaves one cycle earlier to put data out before the ack
  localparam logic [CNT_W-1:0] WR_LO = CNT_W'(MIN_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LO = CNT_W'(MIN_CYC - 2);
  localparam logic [CNT_W-1:0] WR_HI = CNT_W'(MAX_CYC - 1);
  localparam logic [CNT_W-1:0] RD_HI = CNT_W'(MAX_CYC - 2);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(MAX_CYC);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] lo_w;
  logic [CNT_W-1:0] hi_w;

  // Counter restarts on every access and saturates so it never wraps
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
    end
    else if (start)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q != CNT_TOP)
    begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Early answers wait for the floor; late answers are forced at the ceiling
  assign lo_w = is_read ? RD_LO : WR_LO;
  assign hi_w = is_read ? RD_HI : WR_HI;
  assign fire = armed && ((done && (cnt_q >= lo_w)) || (cnt_q >= hi_w)); // R6
  assign count = cnt_q;

endmodule // cbap_ack_timer

// ### cbap_port.sv
// Host processor access port: strobe handshake in two styles, request to the
// internal register file or external memory, and completion timing.
// Assumes host pins are synchronous to clock; pad logic resolves the enables.
// Contract
// R1 - Separate strobes: access runs while chip select and read or write strobe are low.
// R2 - Data strobe: access runs while chip select and data strobe low; direction picks.
// R3 - Host keeps address and memory select stable through the whole access.
// R4 - Host keeps the direction line stable through a data strobe access.
// R5 - Separate strobes: ready driven not-ready within one cycle of access start.
// R6 - Completion signalled no sooner than 6, no later than 60 cycles after start.
// R7 - Separate-strobe read: data valid one cycle before ready rises.
// R8 - Data-strobe read: data valid one cycle before acknowledge falls.
// R9 - After a read ends, data held one cycle then bus released.
// R10 - Host holds a separate-strobe write active until ready is seen.
// R11 - Host drives write data by strobe start and holds it to the end.
// R12 - Data strobe: acknowledge driven high within two cycles of access start.
// R13 - Data-strobe end: acknowledge driven high, then released.
// R14 - Memory select steers each word access to registers or external memory.
// R15 - A configuration input picks the strobe style; only its signals count.
`timescale 1ns/10ps
module cbap_port #(
  parameter int MIN_CYC = cbap_pkg::MIN_ACK_CYC,
  parameter int MAX_CYC = cbap_pkg::MAX_ACK_CYC
) (
  input wire logic clock, // Master clock, 20 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic strobe_mode, // 0 separate strobes, 1 data strobe
  input wire logic chip_select_n, // Chip select
  input wire logic read_strobe_n, // Read strobe, separate style
  input wire logic write_strobe_n, // Write strobe, separate style
  input wire logic data_strobe_n, // Data strobe, data strobe style
  input wire logic read_not_write, // Direction, data strobe style
  input wire logic [cbap_pkg::ADDR_W-1:0] addr, // Word address
  input wire logic memory_space_select, // 1 external memory, 0 registers
  input wire logic [cbap_pkg::DATA_W-1:0] data_in, // Data bus input
  output logic [cbap_pkg::DATA_W-1:0] data_out, // Data bus output
  output logic data_oe, // Data bus drive enable
  output logic ready, // Ready level, separate style
  output logic ready_oe, // Ready drive enable
  output logic data_acknowledge_n, // Acknowledge level, data strobe style
  output logic data_acknowledge_n_oe, // Acknowledge drive enable
  output logic reg_req_valid, // Request pulse to the register file
  output logic mem_req_valid, // Request pulse to the memory controller
  output cbap_pkg::cbap_req_t req, // Request contents
  input cbap_pkg::cbap_rsp_t rsp // Internal answer
);

  typedef enum logic [2:0] {IDLE_S, WAIT_S, DATA_S, ACK_S, END_S} cbap_state_t;

  cbap_state_t state_q;
  cbap_state_t state_d;
  logic mode_q;
  logic rd_q;
  logic done_q;
  logic [cbap_pkg::DATA_W-1:0] rdata_q;
  logic mode_w;
  logic active_w;
  logic start_w;
  logic fire_w;
  logic done_w;
  logic [cbap_pkg::CNT_W-1:0] count_w;
  logic enter_ack_w;
  logic enter_end_w;

  // Style is sampled at the start so a config change cannot tear an access
  assign mode_w = (state_q == IDLE_S) ? strobe_mode : mode_q; // R15
  assign active_w = !chip_select_n && ((mode_w == cbap_pkg::MODE_DATA_STROBE) ?
                    !data_strobe_n : (!read_strobe_n || !write_strobe_n)); // R1 R2
  assign start_w = (state_q == IDLE_S) && active_w;
  assign done_w = done_q || rsp.done;
  assign enter_ack_w = (state_d == ACK_S) && (state_q != ACK_S);
  assign enter_end_w = (state_d == END_S) && (state_q != END_S);

  cbap_ack_timer #(
    .MIN_CYC(MIN_CYC),
    .MAX_CYC(MAX_CYC),
    .CNT_W(cbap_pkg::CNT_W)
  ) u_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(start_w),
    .armed(state_q == WAIT_S),
    .is_read(rd_q),
    .done(done_w),
    .count(count_w),
    .fire(fire_w)
  );

  // Access sequencing; a strobe released early aborts from any busy state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      IDLE_S: if (active_w) state_d = WAIT_S;
      WAIT_S:
      begin
        if (!active_w) state_d = END_S; // R1 R2
        else if (fire_w) state_d = rd_q ? DATA_S : ACK_S; // R6
      end
      DATA_S: state_d = active_w ? ACK_S : END_S; // R7 R8
      ACK_S: if (!active_w) state_d = END_S;
      END_S: state_d = IDLE_S;
      default: state_d = IDLE_S;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst) state_q <= IDLE_S;
    else state_q <= state_d;
  end

  // Access attributes and request, captured on the start edge
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_q <= cbap_pkg::MODE_SEPARATE;
      rd_q <= 1'h0;
      req <= '0;
      reg_req_valid <= 1'h0;
      mem_req_valid <= 1'h0;
    end
    else
    begin
      reg_req_valid <= 1'h0;
      mem_req_valid <= 1'h0;
      if (start_w)
      begin
        mode_q <= strobe_mode;
        rd_q <= (strobe_mode == cbap_pkg::MODE_DATA_STROBE) ? read_not_write : !read_strobe_n;
        req.write <= (strobe_mode == cbap_pkg::MODE_DATA_STROBE) ? !read_not_write
                     : read_strobe_n;
        req.mem <= memory_space_select;
        req.addr <= addr;
        req.wdata <= data_in;
        reg_req_valid <= (memory_space_select == cbap_pkg::SPACE_REGISTERS); // R14
        mem_req_valid <= (memory_space_select == cbap_pkg::SPACE_MEMORY); // R14
      end
    end
  end

  // Answer latch; an answer arriving on the clearing edge is not taken
  // because the request goes out only after start
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_q <= 1'h0;
      rdata_q <= '0;
    end
    else if (rsp.done && state_q != IDLE_S)
    begin
      done_q <= 1'h1;
      rdata_q <= rsp.rdata;
    end
    else if (start_w)
    begin
      done_q <= 1'h0;
    end
  end

  // Read data goes out one cycle ahead of the completion signal
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_out <= '0;
      data_oe <= 1'h0;
    end
    else if (state_d == DATA_S && state_q != DATA_S)
    begin
      data_out <= rsp.done ? rsp.rdata : rdata_q; // R7 R8
      data_oe <= 1'h1; // R7 R8
    end
    else if (state_q == END_S)
    begin
      data_oe <= 1'h0; // R9
    end
  end

  // Ready pin, separate style: pulled not-ready at start, raised to complete
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ready <= cbap_pkg::READY_IDLE;
      ready_oe <= 1'h0;
    end
    else if (start_w && strobe_mode == cbap_pkg::MODE_SEPARATE)
    begin
      ready <= 1'h0; // R5
      ready_oe <= 1'h1; // R5
    end
    else if (enter_ack_w && mode_q == cbap_pkg::MODE_SEPARATE)
    begin
      ready <= 1'h1; // R6
    end
    else if (enter_end_w)
    begin
      ready <= cbap_pkg::READY_IDLE;
      ready_oe <= 1'h0;
    end
  end

  // Acknowledge pin: driven high early so a floating line is never read as
  // an ack, driven high again at the end before release
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_acknowledge_n <= cbap_pkg::DACK_N_IDLE;
      data_acknowledge_n_oe <= 1'h0;
    end
    else if (start_w && strobe_mode == cbap_pkg::MODE_DATA_STROBE)
    begin
      data_acknowledge_n <= 1'h1; // R12
      data_acknowledge_n_oe <= 1'h1; // R12
    end
    else if (enter_ack_w && mode_q == cbap_pkg::MODE_DATA_STROBE)
    begin
      data_acknowledge_n <= 1'h0; // R6
    end
    else if (enter_end_w)
    begin
      data_acknowledge_n <= 1'h1; // R13
    end
    else if (state_q == END_S)
    begin
      data_acknowledge_n_oe <= 1'h0; // R13
    end
  end

  // Checks on the handshake
  localparam logic [cbap_pkg::CNT_W-1:0] CEIL_CNT = MAX_CYC[cbap_pkg::CNT_W-1:0];
  logic ack_any_w;
  assign ack_any_w = (ready && ready_oe) || (!data_acknowledge_n && data_acknowledge_n_oe);

  AST_NOT_READY_FAST: assert property (@(posedge clock) disable iff (sys_rst) // R5
    start_w && strobe_mode == cbap_pkg::MODE_SEPARATE |=> ready_oe && !ready)
    else $error("ready not pulled low after access start");
  AST_ACK_NOT_EARLY: assert property (@(posedge clock) disable iff (sys_rst) // R6
    start_w |=> !ack_any_w [*6])
    else $error("completion signalled too early");
  AST_ACK_NOT_LATE: assert property (@(posedge clock) disable iff (sys_rst) // R6
    (state_q == WAIT_S || state_q == DATA_S) |-> count_w < CEIL_CNT)
    else $error("completion later than ceiling");
  AST_READ_DATA_SETUP: assert property (@(posedge clock) disable iff (sys_rst) // R7
    $rose(ack_any_w) && rd_q |-> data_oe && $past(data_oe))
    else $error("read data not valid a cycle before completion");
  AST_DACK_HIGH_EARLY: assert property (@(posedge clock) disable iff (sys_rst) // R12
    start_w && strobe_mode == cbap_pkg::MODE_DATA_STROBE |=>
      data_acknowledge_n_oe && data_acknowledge_n)
    else $error("acknowledge not driven high after start");
  AST_DACK_END_RELEASE: assert property (@(posedge clock) disable iff (sys_rst) // R13
    state_q == ACK_S && !active_w && mode_q == cbap_pkg::MODE_DATA_STROBE |=>
      data_acknowledge_n_oe && data_acknowledge_n ##1 !data_acknowledge_n_oe)
    else $error("acknowledge not driven high then released");
  AST_DATA_RELEASE: assert property (@(posedge clock) disable iff (sys_rst) // R9
    state_q == ACK_S && !active_w && rd_q |=> data_oe ##1 !data_oe)
    else $error("read data not held then released");
  AST_ONE_REQUEST: assert property (@(posedge clock) disable iff (sys_rst) // R14
    start_w |=> (reg_req_valid != mem_req_valid) && req.mem == $past(memory_space_select)
      ##1 !reg_req_valid && !mem_req_valid)
    else $error("request not a single steered pulse");
  AST_STYLE_ONLY: assert property (@(posedge clock) disable iff (sys_rst) // R15
    state_q != IDLE_S && mode_q == cbap_pkg::MODE_SEPARATE |-> !data_acknowledge_n_oe)
    else $error("acknowledge driven in separate strobe style");

endmodule // cbap_port

// ### cbap_host_model.sv
// Behavioural host processor on the parallel bus of the access port.
// Assumes a free-running master clock; drives and samples at falling edges.
`timescale 1ns/10ps
module cbap_host_model (
  input wire logic clock, // Master clock
  output logic chip_select_n, // Chip select
  output logic read_strobe_n, // Read strobe
  output logic write_strobe_n, // Write strobe
  output logic data_strobe_n, // Data strobe
  output logic read_not_write, // Direction
  output logic [cbap_pkg::ADDR_W-1:0] addr, // Word address
  output logic memory_space_select, // Space select
  output logic [cbap_pkg::DATA_W-1:0] data_in, // Write data
  input wire logic [cbap_pkg::DATA_W-1:0] data_out, // Read data
  input wire logic data_oe, // Read data enable
  input wire logic ready, // Ready level
  input wire logic data_acknowledge_n // Acknowledge level
);
  // Idle bus: strobes high, address lines parked
  initial
  begin
    {chip_select_n, read_strobe_n, write_strobe_n, data_strobe_n} = 4'hF;
    {read_not_write, memory_space_select, addr, data_in} = '0;
  end

  // One access; abort at a cycle other than -1 drops the strobes before completion
  task automatic access(input logic style, input logic rd, input logic mem,
    input logic [14:0] a, input logic [15:0] wd, input int abort,
    output int k, output logic [15:0] rdat, output logic oe_early);
    int j;
    logic oe_prev;
    k = -1;
    j = 0;
    rdat = 16'h0000;
    oe_early = 1'h0;
    oe_prev = 1'h0;
    @(negedge clock);
    {addr, memory_space_select, read_not_write} = {a, mem, rd};
    data_in = wd;
    chip_select_n = 1'h0;
    if (style)
      data_strobe_n = 1'h0;
    else if (rd)
      read_strobe_n = 1'h0;
    else
      write_strobe_n = 1'h0;
    // Outputs seen at each falling edge belong to the rising edge just before
    while (k < 0 && j != abort && j < 80)
    begin
      @(negedge clock);
      if (style ? data_acknowledge_n === 1'h0 : ready === 1'h1)
      begin
        k = j;
        rdat = data_out;
        oe_early = oe_prev;
      end
      oe_prev = data_oe;
      j++;
    end
    if (k >= 0)
      @(negedge clock); // held until a rising edge has seen completion
    {chip_select_n, read_strobe_n, write_strobe_n, data_strobe_n} = 4'hF;
    // Released lines must not keep showing the old value
    {addr, memory_space_select, read_not_write} = {~a, ~mem, ~rd};
    data_in = ~wd;
  endtask
endmodule // cbap_host_model

// ### cbap_port_test.sv
// Self-checking bench for the host access port, with a host model and an
// internal responder. Assumes the port and host model files are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module cbap_port_test;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic strobe_mode = 1'h0;
  logic chip_select_n, read_strobe_n, write_strobe_n, data_strobe_n, read_not_write;
  logic memory_space_select, data_oe, ready, ready_oe;
  logic data_acknowledge_n, data_acknowledge_n_oe, reg_req_valid, mem_req_valid;
  logic [14:0] addr;
  logic [15:0] data_in, data_out, rsp_data = 16'h0000;
  logic [3:0] snap;
  cbap_pkg::cbap_req_t req, last_req;
  cbap_pkg::cbap_rsp_t rsp = '0;
  int mismatches = 0, tests_run = 0, rsp_delay = 0, wait_cnt = -1;
  int reg_pulses = 0, mem_pulses = 0, k;
  logic [15:0] rdat;
  logic oe_early;

  always #25 clock = ~clock;

  cbap_port uut (.clock(clock), .sys_rst(sys_rst), .strobe_mode(strobe_mode),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_strobe_n(data_strobe_n),
    .read_not_write(read_not_write), .addr(addr),
    .memory_space_select(memory_space_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready(ready), .ready_oe(ready_oe),
    .data_acknowledge_n(data_acknowledge_n),
    .data_acknowledge_n_oe(data_acknowledge_n_oe), .reg_req_valid(reg_req_valid),
    .mem_req_valid(mem_req_valid), .req(req), .rsp(rsp));

  cbap_host_model host (.clock(clock), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .data_strobe_n(data_strobe_n), .read_not_write(read_not_write), .addr(addr),
    .memory_space_select(memory_space_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready(ready),
    .data_acknowledge_n(data_acknowledge_n));

  // Internal side answers rsp_delay cycles after each request; -1 never answers
  always @(negedge clock)
  begin
    if (reg_req_valid | mem_req_valid)
    begin
      reg_pulses += reg_req_valid;
      mem_pulses += mem_req_valid;
      last_req = req;
      wait_cnt = rsp_delay;
      snap = {ready_oe, ready, data_acknowledge_n_oe, data_acknowledge_n};
    end
    rsp <= (wait_cnt == 0) ? {1'h1, rsp_data} : '0;
    if (wait_cnt >= 0)
      wait_cnt--;
  end

  task automatic end_sim;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Two cycles after the host lets go: acknowledge high first, then all released
  task automatic end_check(input logic style, input logic rd);
    @(negedge clock);
    `CHK("ready_oe at end", 1'h0, ready_oe)
    `CHK("ack level at end", 1'h1, data_acknowledge_n)
    `CHK("ack drive at end", style, data_acknowledge_n_oe)
    `CHK("data hold at end", rd, data_oe)
    @(negedge clock);
    `CHK("ack release", 1'h0, data_acknowledge_n_oe)
    `CHK("data release", 1'h0, data_oe)
  endtask

  // Separate-strobe register write with an early answer completes at the floor
  task automatic t_sep_write;
    strobe_mode = 1'h0;
    rsp_delay = 0;
    host.access(1'h0, 1'h0, 1'h0, 15'h1234, 16'hBEEF, -1, k, rdat, oe_early);
    `CHK("write latency", 6, k)
    `CHK("start outputs", 4'h9, snap)
    `CHK("register pulses", 1, reg_pulses)
    `CHK("request", {1'h1, 1'h0, 15'h1234, 16'hBEEF}, last_req)
    end_check(1'h0, 1'h0);
  endtask

  // Data-strobe memory read answered late: two cycles after the answer
  task automatic t_ds_read;
    strobe_mode = 1'h1;
    rsp_delay = 20;
    rsp_data = 16'hA5C3;
    host.access(1'h1, 1'h1, 1'h1, 15'h7FFF, 16'h0000, -1, k, rdat, oe_early);
    `CHK("ds read latency", 22, k)
    `CHK("start outputs", 4'h3, snap)
    `CHK("read data", 16'hA5C3, rdat)
    `CHK("data before ack", 1'h1, oe_early)
    `CHK("memory pulses", 1, mem_pulses)
    `CHK("request kind", 2'h1, {last_req.write, last_req.mem})
    end_check(1'h1, 1'h1);
  endtask

  // Separate-strobe read never answered is completed at the ceiling
  task automatic t_sep_timeout;
    strobe_mode = 1'h0;
    rsp_delay = -1;
    host.access(1'h0, 1'h1, 1'h0, 15'h0001, 16'h0000, -1, k, rdat, oe_early);
    `CHK("timeout latency", 60, k)
    `CHK("held read data", 16'hA5C3, rdat)
    `CHK("data before ready", 1'h1, oe_early)
    end_check(1'h0, 1'h1);
  endtask

  // Data-strobe write, then an aborted write, then the wrong strobe style
  task automatic t_abort_style;
    strobe_mode = 1'h1;
    rsp_delay = 3;
    host.access(1'h1, 1'h0, 1'h0, 15'h0ABC, 16'h0F0F, -1, k, rdat, oe_early);
    `CHK("ds write latency", 6, k)
    end_check(1'h1, 1'h0);
    strobe_mode = 1'h0;
    rsp_delay = 0;
    host.access(1'h0, 1'h0, 1'h1, 15'h0055, 16'h1111, 3, k, rdat, oe_early);
    `CHK("aborted write", -1, k)
    end_check(1'h0, 1'h0);
    host.access(1'h1, 1'h1, 1'h0, 15'h0066, 16'h0000, 10, k, rdat, oe_early);
    `CHK("ignored style", -1, k)
    `CHK("pulses total", 5, reg_pulses + mem_pulses)
    end_check(1'h0, 1'h0);
  endtask

  // Watchdog: the whole sequence needs about 135 cycles
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    repeat (2) @(negedge clock);
    sys_rst = 1'h0;
    `CHK("idle enables", 3'h0, {ready_oe, data_oe, data_acknowledge_n_oe})
    `CHK("idle ack level", 1'h1, data_acknowledge_n)
    t_sep_write();
    t_ds_read();
    t_sep_timeout();
    t_abort_style();
    end_sim();
  end
endmodule // cbap_port_test
